/* File: hw/ipcd_input_port.v */
// Input port with pin levels, alternate-function routing and change detection,
// followed by the small rising-edge divider that serves the external clock pins.
// Assumes APB from a host on clock_i and asynchronous pins that need synchronising.
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "ipcd_defs.vh"

// Behaviour
// - External 16X pin clocks are divided by sixteen; 1X clocks pass undivided.
// - Pin-level register returns live level of pin n in bit n.
// - Pin levels read true regardless of alternate function assignment.
// - Pin 0 is channel A active-low clear-to-send when mode2 A bit 4 set.
// - Pin 1 is channel B active-low clear-to-send when mode2 B bit 4 set.
// - Pin 2 clocks the timer when auxiliary control bits 6:4 are zero.
// - Pin 2 clocks channel B receiver when select B upper nibble is E or F.
// - Pin 3 clocks channel A transmitter when select A lower nibble is E or F.
// - Pin 4 clocks channel A receiver when select A upper nibble is E or F.
// - Pin 5 clocks channel B transmitter when select B lower nibble is E or F.
// - Pins 0 to 3 have change detectors sampled by a 38.4 kHz tick.
// - A change lasting two sample periods sets its change flag, unless it comes before the first tick after reset.
// - Reading the change register clears flags 7:4 but not level bits.
// - Change register bits 7:4 are change flags for pins 3 to 0.
// - Change register bits 3:0 show present levels of pins 3 to 0.
// - Auxiliary control bits 3:0 enable change interrupt per pin.
// - Interrupt mask bit 7 is the global change interrupt enable.
module ipcd_input_port #(
    parameter SAMPLE_DIV = `IPCD_SAMPLE_DIV
) (
    input wire clock_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire [5:0] input_pin_i,
    output reg clear_to_send_a_n_o,
    output reg clear_to_send_b_n_o,
    output reg timer_ext_clock_in_o,
    output reg rx_clock_in_a_o,
    output reg tx_clock_in_a_o,
    output reg rx_clock_in_b_o,
    output reg tx_clock_in_b_o,
    output wire change_irq_o,
    output wire irq_o
);

    reg [5:0] sync1_q;
    reg [5:0] sync2_q;
    reg [7:0] aux_control_q;
    reg [7:0] irq_mask_reg_q;
    reg [7:0] mode_two_chan_a_q;
    reg [7:0] mode_two_chan_b_q;
    reg [7:0] clock_select_chan_a_q;
    reg [7:0] clock_select_chan_b_q;
    reg [3:0] flags_q;
    reg [3:0] samp_q;
    reg [3:0] samp_prev_q;
    reg [31:0] tick_cnt_q;
    reg tick_q;
    reg [1:0] irq_stat_q;
    reg [1:0] irq_en_q;
    reg [1:0] samp_warm_q;
    reg [31:0] rdata_q;
    reg slverr_q;
    reg [31:0] rd_mux;
    reg rd_hit;
    wire access;
    wire wr;
    wire rd;
    wire [3:0] change_set;
    wire [1:0] ev;
    wire div_rxa;
    wire div_txa;
    wire div_rxb;
    wire div_txb;

    // Divider width follows the external clock ratio, four bits for a 16X pin.
    localparam X16_BITS = $clog2(`IPCD_X16_DIV);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    // Only the second stage is read by logic, to keep metastability contained.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= input_pin_i;
            sync2_q <= sync1_q;
        end
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states; read data is registered in the setup cycle.
    assign access = psel_i & penable_i;
    assign wr = access & pwrite_i;
    assign rd = access & ~pwrite_i;
    assign pready_o = 1'b1;
    assign prdata_o = rdata_q;
    assign pslverr_o = slverr_q & access;

    // Read decode; unmapped addresses answer zero with an error.
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr_i)
            `IPCD_OFS_PIN_LEVEL: rd_mux = {26'h0, sync2_q};
            `IPCD_OFS_CHANGE: rd_mux = {24'h000000, flags_q, sync2_q[3:0]};
            `IPCD_OFS_AUX_CTRL: rd_mux = {24'h000000, aux_control_q};
            `IPCD_OFS_IRQ_MASK: rd_mux = {24'h000000, irq_mask_reg_q};
            `IPCD_OFS_MODE2_A: rd_mux = {24'h000000, mode_two_chan_a_q};
            `IPCD_OFS_MODE2_B: rd_mux = {24'h000000, mode_two_chan_b_q};
            `IPCD_OFS_CSEL_A: rd_mux = {24'h000000, clock_select_chan_a_q};
            `IPCD_OFS_CSEL_B: rd_mux = {24'h000000, clock_select_chan_b_q};
            `IPCD_OFS_IRQ_STAT: rd_mux = {30'h0, irq_stat_q};
            `IPCD_OFS_IRQ_CLR: rd_mux = 32'h00000000;
            `IPCD_OFS_IRQ_EN: rd_mux = {30'h0, irq_en_q};
            default: rd_hit = 1'b0;
        endcase
    end

    // Capture read data during setup so the access phase shows it.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h00000000;
            slverr_q <= 1'b0;
        end else if (psel_i && !penable_i) begin
            rdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
            slverr_q <= ~rd_hit;
        end
    end

    // Writable configuration registers.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_control_q <= `IPCD_RST_BYTE;
            irq_mask_reg_q <= `IPCD_RST_BYTE;
            mode_two_chan_a_q <= `IPCD_RST_BYTE;
            mode_two_chan_b_q <= `IPCD_RST_BYTE;
            clock_select_chan_a_q <= `IPCD_RST_BYTE;
            clock_select_chan_b_q <= `IPCD_RST_BYTE;
            irq_en_q <= 2'h0;
        end else if (wr) begin
            case (paddr_i)
                `IPCD_OFS_AUX_CTRL: aux_control_q <= pwdata_i[7:0];
                `IPCD_OFS_IRQ_MASK: irq_mask_reg_q <= pwdata_i[7:0];
                `IPCD_OFS_MODE2_A: mode_two_chan_a_q <= pwdata_i[7:0];
                `IPCD_OFS_MODE2_B: mode_two_chan_b_q <= pwdata_i[7:0];
                `IPCD_OFS_CSEL_A: clock_select_chan_a_q <= pwdata_i[7:0];
                `IPCD_OFS_CSEL_B: clock_select_chan_b_q <= pwdata_i[7:0];
                `IPCD_OFS_IRQ_EN: irq_en_q <= pwdata_i[1:0];
                default: irq_en_q <= irq_en_q;
            endcase
        end
    end

    // ****************************************************************
    // Sample tick and change detection
    // ****************************************************************
    // Divider standing in for the bit rate generator's 38.4 kHz output.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= SAMPLE_DIV - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end

    // Two-sample history: a level differing across one tick sets the flag,
    // so any change held for two periods is caught, except one made before the first tick after reset.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            samp_q <= 4'h0;
            samp_prev_q <= 4'h0;
        end else if (tick_q) begin
            samp_q <= sync2_q[3:0];
            samp_prev_q <= samp_q;
        end
    end

    // The first two samples after reset hold the reset value, not the pins, so a
    // pin held high through reset would otherwise raise a false change flag.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            samp_warm_q <= 2'h0;
        end else if (tick_q && samp_warm_q != 2'h2) begin
            samp_warm_q <= samp_warm_q + 2'h1;
        end
    end

    assign change_set = (tick_q && samp_warm_q == 2'h2) ? (samp_q ^ samp_prev_q) : 4'h0;

    // Flags clear on a change-register read; a simultaneous set wins.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_q <= 4'h0;
        end else if (rd && paddr_i == `IPCD_OFS_CHANGE) begin
            // Only flags shown by the setup snapshot are cleared, so a change that
            // lands between setup and access survives for the next read.
            flags_q <= (flags_q & ~rdata_q[7:4]) | change_set;
        end else begin
            flags_q <= flags_q | change_set;
        end
    end

    assign change_irq_o = (|(flags_q & aux_control_q[3:0]))
        & irq_mask_reg_q[`IPCD_IMR_IPC_BIT];

    // ****************************************************************
    // Sticky event status and interrupt
    // ****************************************************************
    // Bit 0 is a new change flag, bit 1 a change-read event; set beats clear.
    assign ev = {rd && paddr_i == `IPCD_OFS_CHANGE, |change_set};

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_q <= 2'h0;
        end else if (wr && paddr_i == `IPCD_OFS_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~pwdata_i[1:0]) | ev;
        end else begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    assign irq_o = |(irq_stat_q & irq_en_q);

    // ****************************************************************
    // Alternate-function routing
    // ****************************************************************
    // One divider per external clock pin, each fed by its synchronised level.
    // They free-run whatever the clock select, so switching to 16X needs no restart.
    ipcd_edge_div #(
        .CNT_BITS(X16_BITS)
    ) u_div_rxa (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .level_i(sync2_q[4]),
        .div_o(div_rxa)
    );

    ipcd_edge_div #(
        .CNT_BITS(X16_BITS)
    ) u_div_txa (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .level_i(sync2_q[3]),
        .div_o(div_txa)
    );

    ipcd_edge_div #(
        .CNT_BITS(X16_BITS)
    ) u_div_rxb (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .level_i(sync2_q[2]),
        .div_o(div_rxb)
    );

    ipcd_edge_div #(
        .CNT_BITS(X16_BITS)
    ) u_div_txb (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .level_i(sync2_q[5]),
        .div_o(div_txb)
    );

    // Registered routing: an unselected function idles (CTS inactive high, clocks low).
    // The divided clock's MSB is a square wave at one sixteenth of the pin rate.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clear_to_send_a_n_o <= 1'b1;
            clear_to_send_b_n_o <= 1'b1;
            timer_ext_clock_in_o <= 1'b0;
            rx_clock_in_a_o <= 1'b0;
            tx_clock_in_a_o <= 1'b0;
            rx_clock_in_b_o <= 1'b0;
            tx_clock_in_b_o <= 1'b0;
        end else begin
            clear_to_send_a_n_o <= mode_two_chan_a_q[`IPCD_MODE2_CTS_BIT] ?
                sync2_q[0] : 1'b1;
            clear_to_send_b_n_o <= mode_two_chan_b_q[`IPCD_MODE2_CTS_BIT] ?
                sync2_q[1] : 1'b1;
            timer_ext_clock_in_o <= (aux_control_q[6:4] == `IPCD_CT_EXT_MODE) ?
                sync2_q[2] : 1'b0;
            rx_clock_in_b_o <= (clock_select_chan_b_q[7:4] == `IPCD_CSEL_EXT16) ? div_rxb :
                (clock_select_chan_b_q[7:4] == `IPCD_CSEL_EXT1) ? sync2_q[2] : 1'b0;
            tx_clock_in_a_o <= (clock_select_chan_a_q[3:0] == `IPCD_CSEL_EXT16) ? div_txa :
                (clock_select_chan_a_q[3:0] == `IPCD_CSEL_EXT1) ? sync2_q[3] : 1'b0;
            rx_clock_in_a_o <= (clock_select_chan_a_q[7:4] == `IPCD_CSEL_EXT16) ? div_rxa :
                (clock_select_chan_a_q[7:4] == `IPCD_CSEL_EXT1) ? sync2_q[4] : 1'b0;
            tx_clock_in_b_o <= (clock_select_chan_b_q[3:0] == `IPCD_CSEL_EXT16) ? div_txb :
                (clock_select_chan_b_q[3:0] == `IPCD_CSEL_EXT1) ? sync2_q[5] : 1'b0;
        end
    end

endmodule

// ****************************************************************
// Rising-edge divider for an external clock pin
// ****************************************************************
// Counts rising edges of an already synchronised level; the counter's top bit
// is a square wave at the pin rate divided by two to the power of CNT_BITS.
// The phase of the divided clock is arbitrary, since the count never restarts;
// a receiver relying on it must align itself on the start bit.
module ipcd_edge_div #(
    parameter CNT_BITS = 4
) (
    input wire clock_i,
    input wire nrst_i,
    input wire level_i,
    output wire div_o
);

    reg level_prev_q;
    reg [CNT_BITS-1:0] cnt_q;

    // The input is synchronised upstream, so one history stage is enough here.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_prev_q <= 1'b0;
            cnt_q <= {CNT_BITS{1'b0}};
        end else begin
            level_prev_q <= level_i;
            if (level_i && !level_prev_q) begin
                cnt_q <= cnt_q + {{(CNT_BITS-1){1'b0}}, 1'b1};
            end
        end
    end

    assign div_o = cnt_q[CNT_BITS-1];

endmodule

/* File: pkg/ipcd_defs.vh */
// Constants for the input port change detector: register offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef IPCD_DEFS_VH
`define IPCD_DEFS_VH

// ****************************************************************
// Register byte offsets on APB
// ****************************************************************
`define IPCD_OFS_PIN_LEVEL 12'h000
`define IPCD_OFS_CHANGE 12'h004
`define IPCD_OFS_AUX_CTRL 12'h008
`define IPCD_OFS_IRQ_MASK 12'h00C
`define IPCD_OFS_MODE2_A 12'h010
`define IPCD_OFS_MODE2_B 12'h014
`define IPCD_OFS_CSEL_A 12'h018
`define IPCD_OFS_CSEL_B 12'h01C
`define IPCD_OFS_IRQ_STAT 12'h020
`define IPCD_OFS_IRQ_CLR 12'h024
`define IPCD_OFS_IRQ_EN 12'h028

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define IPCD_MODE2_CTS_BIT 4
`define IPCD_IMR_IPC_BIT 7
`define IPCD_CSEL_EXT16 4'hE
`define IPCD_CSEL_EXT1 4'hF
`define IPCD_CT_EXT_MODE 3'h0

// ****************************************************************
// Reset values
// ****************************************************************
`define IPCD_RST_BYTE 8'h00

// ****************************************************************
// Timing: sample tick rate, system clock and external clock ratio
// ****************************************************************
`define IPCD_CLK_HZ 125000000
`define IPCD_SAMPLE_HZ 38400
`define IPCD_SAMPLE_DIV (`IPCD_CLK_HZ / `IPCD_SAMPLE_HZ)
`define IPCD_X16_DIV 16

`endif

/* File: tb/ipcd_input_port_checker.sv */
// Checker for the input port change detector, bound to its top module.
// Assumes zero-wait APB and routing outputs that trail the pins by three clocks.
`timescale 1ns/10ps
`include "ipcd_defs.vh"
module ipcd_chk (
    input wire clock_i,
    input wire nrst_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire [5:0] input_pin_i,
    input wire clear_to_send_a_n_o,
    input wire clear_to_send_b_n_o,
    input wire timer_ext_clock_in_o,
    input wire rx_clock_in_b_o,
    input wire change_irq_o
);
    reg [7:0] aux_q;
    reg [7:0] mask_q;
    reg [7:0] cselb_q;
    reg [1:0] age_q;
    wire wr_w = psel_i && penable_i && pwrite_i && pready_o;
    // Shadows of the controls; age_q hides the synchroniser refill after reset.
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            aux_q <= 8'h00;
            mask_q <= 8'h00;
            cselb_q <= 8'h00;
            age_q <= 2'h0;
        end else begin
            age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
            if (wr_w && paddr_i == `IPCD_OFS_AUX_CTRL) aux_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == `IPCD_OFS_IRQ_MASK) mask_q <= pwdata_i[7:0];
            if (wr_w && paddr_i == `IPCD_OFS_CSEL_B) cselb_q <= pwdata_i[7:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    a_zero_wait: assert property (s_setup ##1 s_access |-> pready_o)
        else $error("Access phase without ready.");
    a_err_in_access: assert property (pslverr_o |-> psel_i && penable_i)
        else $error("Error outside an access phase.");
    a_cts_a_cause: assert property (!clear_to_send_a_n_o |-> !$past(input_pin_i[0], 3))
        else $error("Channel A clear-to-send low without a low pin.");
    a_cts_b_cause: assert property (!clear_to_send_b_n_o |-> !$past(input_pin_i[1], 3))
        else $error("Channel B clear-to-send low without a low pin.");
    a_timer_route: assert property (age_q == 2'h3 && aux_q[6:4] == 3'h0 && $stable(aux_q)
        |-> timer_ext_clock_in_o == $past(input_pin_i[2], 3))
        else $error("Timer clock does not follow its pin.");
    a_timer_idle: assert property (aux_q[6:4] != 3'h0 && $stable(aux_q)
        |-> !timer_ext_clock_in_o)
        else $error("Timer clock active while not selected.");
    a_rxb_route: assert property (age_q == 2'h3 && cselb_q[7:4] == 4'hF && $stable(cselb_q)
        |-> rx_clock_in_b_o == $past(input_pin_i[2], 3))
        else $error("Receiver B clock does not follow its pin.");
    a_change_irq_gate: assert property ((!mask_q[7] || aux_q[3:0] == 4'h0)
        |-> !change_irq_o)
        else $error("Change request while disabled.");
endmodule
bind ipcd_input_port ipcd_chk u_chk (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .input_pin_i(input_pin_i),
    .clear_to_send_a_n_o(clear_to_send_a_n_o),
    .clear_to_send_b_n_o(clear_to_send_b_n_o),
    .timer_ext_clock_in_o(timer_ext_clock_in_o),
    .rx_clock_in_b_o(rx_clock_in_b_o),
    .change_irq_o(change_irq_o)
);

/* File: tb/ipcd_input_port_tb.sv */
// Bench for the input port change detector: APB host, pin source, read scoreboard.
// Assumes the pin source model and the bound checker are compiled before it.
`timescale 1ns/10ps
`include "ipcd_defs.vh"
module ipcd_input_port_tb;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [5:0] lvl = 6'h00;
    logic [5:0] cen = 6'h00;
    wire [5:0] input_pin_i;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, clear_to_send_a_n_o, clear_to_send_b_n_o, timer_ext_clock_in_o;
    wire rx_clock_in_a_o, tx_clock_in_a_o, rx_clock_in_b_o, tx_clock_in_b_o, change_irq_o, irq_o;
    integer bad_count = 0;
    integer checks = 0;
    logic [64:0] notes[$];
    logic [31:0] seed = 32'd98;
    logic [31:0] r;
    logic [6:0] e;
    logic [3:0] v, old;
    integer i, p, k, rise[4];
    always #4 clock_i = ~clock_i;
    ipcd_pin_src u_src (.clock_i(clock_i), .level_i(lvl), .clk_en_i(cen), .pins_o(input_pin_i));
    ipcd_input_port #(
        .SAMPLE_DIV(8)
    ) uut (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .input_pin_i(input_pin_i),
        .clear_to_send_a_n_o(clear_to_send_a_n_o),
        .clear_to_send_b_n_o(clear_to_send_b_n_o),
        .timer_ext_clock_in_o(timer_ext_clock_in_o),
        .rx_clock_in_a_o(rx_clock_in_a_o),
        .tx_clock_in_a_o(tx_clock_in_a_o),
        .rx_clock_in_b_o(rx_clock_in_b_o),
        .tx_clock_in_b_o(tx_clock_in_b_o),
        .change_irq_o(change_irq_o),
        .irq_o(irq_o)
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cyc(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic close_out();
        $display("Counts: %0d checks, %0d mismatches.", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp_pin(input string nm, input logic [6:0] ex, input logic [6:0] s);
        checks++;
        if (s !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %b seen %b", nm, ex, s);
        end
    endtask
    task automatic cmp_rd(input logic [64:0] n);
        checks++;
        if ((prdata_o & n[63:32]) !== n[31:0] || pslverr_o !== n[64]) begin
            bad_count++;
            $display("MISMATCH read expected %h/%b seen %h/%b", n[31:0], n[64], prdata_o, pslverr_o);
        end
    endtask
    // One APB transfer; the request is held until ready is seen at a rising edge.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        integer n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (!pready_o && n < 16);
        if (!pready_o) begin
            bad_count++;
            close_out();
        end else begin
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ex);
        notes.push_back({1'b0, m, ex});
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, {24'h0, d});
    endtask
    // Read data is taken at the rising edge that samples ready high in the access phase.
    always @(posedge clock_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o) cmp_rd(notes.pop_front());
    end
    // Main sequence: levels and routing, divider, change flags, masking.
    initial begin
        cyc(6);
        nrst_i <= 1'b1;
        notes.push_back({1'b1, 64'hFFFFFFFF00000000});
        apb(12'h0FC, 1'b0, 32'h0);
        for (i = 0; i < 12; i++) begin
            if (i == 4) begin
                wr(`IPCD_OFS_MODE2_A, 8'h10);
                wr(`IPCD_OFS_MODE2_B, 8'h10);
                wr(`IPCD_OFS_CSEL_A, 8'hFF);
                wr(`IPCD_OFS_CSEL_B, 8'hFF);
            end
            r = rnd();
            lvl <= r[5:0];
            cyc(6);
            rd(`IPCD_OFS_PIN_LEVEL, 32'h3F, {26'h0, r[5:0]});
            e = (i < 4) ? {4'h0, r[2], 2'h3} : {r[5:2], r[2:0]};
            v = {tx_clock_in_b_o, rx_clock_in_a_o, tx_clock_in_a_o, rx_clock_in_b_o};
            cmp_pin("routes", e, {v, timer_ext_clock_in_o, clear_to_send_b_n_o, clear_to_send_a_n_o});
        end
        $display("Test levels and routing done.");
        wr(`IPCD_OFS_MODE2_A, 8'h00);
        wr(`IPCD_OFS_MODE2_B, 8'h00);
        wr(`IPCD_OFS_CSEL_A, 8'hEE);
        wr(`IPCD_OFS_CSEL_B, 8'hEE);
        wr(`IPCD_OFS_AUX_CTRL, 8'h70);
        lvl <= 6'h00;
        cyc(6);
        @(negedge clock_i);
        old = {tx_clock_in_b_o, rx_clock_in_a_o, tx_clock_in_a_o, rx_clock_in_b_o};
        rise = '{0, 0, 0, 0};
        for (k = 0; k < 140; k++) begin
            @(posedge clock_i);
            if (k == 0) cen <= 6'h3C;
            if (k == 127) cen <= 6'h00;
            @(negedge clock_i);
            v = {tx_clock_in_b_o, rx_clock_in_a_o, tx_clock_in_a_o, rx_clock_in_b_o};
            for (p = 0; p < 4; p++) rise[p] += (v[p] && !old[p]);
            old = v;
        end
        cmp_pin("div16", 7'h0F, {3'h0, rise[3] == 2, rise[2] == 2, rise[1] == 2, rise[0] == 2});
        cmp_pin("idle", 7'h03, {4'h0, timer_ext_clock_in_o, clear_to_send_b_n_o, clear_to_send_a_n_o});
        $display("Test divide by sixteen done.");
        wr(`IPCD_OFS_AUX_CTRL, 8'h0F);
        wr(`IPCD_OFS_IRQ_MASK, 8'h80);
        wr(`IPCD_OFS_IRQ_EN, 8'h01);
        cyc(40);
        for (p = 0; p < 5; p++) begin
            rd(`IPCD_OFS_CHANGE, 32'h0F, 32'h0);
            wr(`IPCD_OFS_IRQ_CLR, 8'h03);
            if (p < 4) begin
                lvl <= 6'h01 << p;
                cyc(30);
                cmp_pin("irqs", 7'h03, {5'h0, change_irq_o, irq_o});
                rd(`IPCD_OFS_CHANGE, 32'hFF, 32'h11 << p);
                rd(`IPCD_OFS_CHANGE, 32'hFF, 32'h01 << p);
                wr(`IPCD_OFS_IRQ_CLR, 8'h03);
                cyc(1);
                cmp_pin("irqs", 7'h00, {5'h0, change_irq_o, irq_o});
                lvl <= 6'h00;
                cyc(30);
            end
        end
        $display("Test change flags done.");
        for (i = 0; i < 2; i++) begin
            wr(`IPCD_OFS_AUX_CTRL, i ? 8'h0F : 8'h0E);
            wr(`IPCD_OFS_IRQ_MASK, i ? 8'h00 : 8'h80);
            wr(`IPCD_OFS_IRQ_EN, 8'h00);
            lvl <= i ? 6'h00 : 6'h01;
            cyc(30);
            cmp_pin("masked", 7'h00, {5'h0, change_irq_o, irq_o});
            rd(`IPCD_OFS_CHANGE, 32'hFF, i ? 32'h10 : 32'h11);
        end
        $display("Test masking done.");
        close_out();
    end
endmodule

/* File: tb/ipcd_pin_src.sv */
// Model of the external signals on the input pins: static levels or a bit clock.
// Assumes the bench changes its requests just after a rising clock edge.
`timescale 1ns/10ps
module ipcd_pin_src (
    input wire clock_i,
    input wire [5:0] level_i,
    input wire [5:0] clk_en_i,
    output reg [5:0] pins_o = 6'h00
);
    reg [1:0] ph_q = 2'h0;
    // The clock stands still outside a burst, so every burst starts low.
    always @(posedge clock_i) begin
        ph_q <= (clk_en_i != 6'h00) ? ph_q + 2'h1 : 2'h0;
        pins_o <= (level_i & ~clk_en_i) | ({6{ph_q[1]}} & clk_en_i);
    end
endmodule
